// File: bench/rtc_host_model.sv
`timescale 1ns/1ps
module rtc_host_model #(
	parameter int HALF_CYCLES = 125
)
(
	input  wire logic ref_clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_pull_o
);
	initial
	begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end

	task automatic wait_n(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask

	// data moves 8 cycles after scl falls so the synchroniser never sees a false start
	// half a bit of 125 cycles keeps the bus at 400 kbit/s, its top rate
	task automatic bit_io(input logic pull, output logic seen);
		scl_o = 1'b0;
		wait_n(8);
		sda_pull_o = pull;
		wait_n(HALF_CYCLES - 8);
		scl_o = 1'b1;
		wait_n(HALF_CYCLES);
		seen = sda_i;
	endtask

	task automatic start();
		logic s;
		bit_io(1'b0, s);
		sda_pull_o = 1'b1;
		wait_n(HALF_CYCLES);
	endtask

	task automatic stop();
		logic s;
		bit_io(1'b1, s);
		sda_pull_o = 1'b0;
		wait_n(HALF_CYCLES);
	endtask

	// reserved bits are always sent as given by the caller, zero in every test
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(~b[i], s);
		bit_io(1'b0, s);
		ack = ~s;
	endtask

	task automatic rbyte(input logic nack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b0, s);
			b[i] = s;
		end
		bit_io(~nack, s);
	endtask
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import rtc_pkg::*;
	logic       ref_clk;
	logic       sys_rst;
	logic       osc_clk;
	logic       osc_run;
	logic       supply_low;
	logic       sda_oe;
	logic       int_oe;
	logic       sqw_oe;
	logic       ack;
	logic       hi;
	logic       lo;
	logic [7:0] rdq [16];
	wire        scl;
	wire        sda_pull;
	// open-drain wire with pull-up
	wire        sda = ~(sda_pull | sda_oe);
	int         mismatches;
	int         num_checks;

	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// oscillator stands still low while stopped
	initial
	begin
		osc_clk = 1'b0;
		#17;
		forever #40 osc_clk = osc_run ? ~osc_clk : 1'b0;
	end

	rtc_core #(.OSC_STOP_CYCLES(40)) dut (
		.ref_clk_i           (ref_clk),
		.sys_rst_i           (sys_rst),
		.osc_clk_i           (osc_clk),
		.scl_i               (scl),
		.sda_i               (sda),
		.sda_o               (),
		.sda_oe_o            (sda_oe),
		.int_o               (),
		.int_oe_o            (int_oe),
		.square_wave_out_o   (),
		.square_wave_out_oe_o(sqw_oe),
		.supply_low_i        (supply_low)
	);

	rtc_host_model host (
		.ref_clk_i (ref_clk),
		.sda_i     (sda),
		.scl_o     (scl),
		.sda_pull_o(sda_pull)
	);

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			$display("unexpected %s expected %h seen %h", name, exp, got);
			mismatches++;
		end
	endtask

	task automatic wregs(input logic [3:0] a, input logic [7:0] d [$]);
		host.start();
		host.wbyte(I2C_ADDR_WR, ack);
		check("write address ack", 8'h01, {7'h00, ack});
		host.wbyte({4'h0, a}, ack);
		foreach (d[i])
			host.wbyte(d[i], ack);
		check("data ack", 8'h01, {7'h00, ack});
		host.stop();
	endtask

	task automatic rregs(input logic [3:0] a, input int n);
		host.start();
		host.wbyte(I2C_ADDR_WR, ack);
		host.wbyte({4'h0, a}, ack);
		host.start();
		host.wbyte(I2C_ADDR_RD, ack);
		check("read address ack", 8'h01, {7'h00, ack});
		for (int i = 0; i < n; i++)
			host.rbyte(i == n - 1, rdq[i]);
		host.stop();
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		// tests take about 100k cycles at the top legal bus rate
		repeat (110000) @(posedge ref_clk);
		mismatches++;
		conclude();
	end

	initial
	begin
		sys_rst = 1'b1;
		osc_run = 1'b1;
		supply_low = 1'b0;
		mismatches = 0;
		num_checks = 0;
		repeat (12) @(posedge ref_clk);
		@(negedge ref_clk);
		sys_rst = 1'b0;
		@(posedge osc_clk);
		#20;
		check("default wave high phase", 8'h00, {7'h00, sqw_oe});
		@(negedge osc_clk);
		#20;
		check("default wave low phase", 8'h01, {7'h00, sqw_oe});
		$display("test default square wave done");

		// pointer is zero after reset, so a bare read address starts at the first register
		host.start();
		host.wbyte(I2C_ADDR_RD, ack);
		check("burst address ack", 8'h01, {7'h00, ack});
		for (int i = 0; i < 16; i++)
			host.rbyte(i == 15, rdq[i]);
		host.stop();
		for (int i = 0; i < 16; i++)
			check("reset value", REG_RST[i], rdq[i]);
		$display("test register burst done");

		host.start();
		host.wbyte(8'hA0, ack);
		check("foreign address ack", 8'h00, {7'h00, ack});
		host.stop();
		$display("test foreign address done");

		// wave 1024 Hz, timer on at 4096 Hz reloading 3
		wregs(REG_SQW, '{8'h81, 8'h80, 8'h03});
		hi = 1'b0;
		lo = 1'b0;
		repeat (64)
		begin
			@(posedge osc_clk);
			#20;
			if (sqw_oe)
				hi = 1'b1;
			else
				lo = 1'b1;
		end
		check("slow wave both levels", 8'h01, {7'h00, hi & lo});
		check("irq without enable", 8'h00, {7'h00, int_oe});
		$display("test wave and timer start done");

		// writing 1 to the done flag leaves it alone
		// the following byte clears the supply-low flag and the seconds
		wregs(REG_CTRL_B, '{8'h05, 8'h00});
		check("level irq", 8'h01, {7'h00, int_oe});
		wregs(REG_TMR_CTL, '{8'h03});
		rregs(REG_CTRL_B, 2);
		check("done flag kept", 8'h05, rdq[0]);
		check("supply flag cleared", 8'h00, rdq[1]);
		@(negedge ref_clk);
		supply_low = 1'b1;
		repeat (4) @(negedge ref_clk);
		supply_low = 1'b0;
		wregs(REG_CTRL_B, '{8'h01});
		check("irq after clear", 8'h00, {7'h00, int_oe});
		$display("test countdown irq done");

		osc_run = 1'b0;
		repeat (100) @(negedge ref_clk);
		osc_run = 1'b1;
		repeat (100) @(negedge ref_clk);
		rregs(REG_SQW, 1);
		check("wave control after stop", REG_RST[REG_SQW], rdq[0]);
		$display("test oscillator stop done");
		conclude();
	end
endmodule

// File: core/rtc_core.sv
`timescale 1ns/1ps
module rtc_core
	import rtc_pkg::*;
#(
	parameter int unsigned OSC_STOP_CYCLES = OSC_STOP_CYCLES_DEF
)
(
	input  wire logic ref_clk_i,
	input  wire logic sys_rst_i,
	input  wire logic osc_clk_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe_o,
	output logic      int_o,
	output logic      int_oe_o,
	output logic      square_wave_out_o,
	output logic      square_wave_out_oe_o,
	input  wire logic supply_low_i
);

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
		ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
	} rtc_state_e;

	typedef struct packed {
		logic [15:0][7:0] regs;
		logic [7:0]       reload;
		rtc_state_e       st;
		logic [3:0]       cnt;
		logic [7:0]       shift;
		logic [3:0]       ptr;
		logic             rw;
		logic             nack;
		logic             sda_oe;
		logic             int_oe;
		logic             sec_pend;
		logic             alarm_chk;
		logic [5:0]       min_div;
		logic [9:0]       pulse;
		logic [16:0]      stall;
		logic [2:0]       scl_s;
		logic [2:0]       sda_s;
		logic [1:0]       low_s;
		logic [2:0]       alive_s;
		logic [2:0]       t4k_s;
		logic [2:0]       t64_s;
		logic [2:0]       t1_s;
	} rtc_ref_s;

	typedef struct packed {
		logic [14:0] pre;
		logic        t4k;
		logic        t64;
		logic        t1;
		logic [1:0]  en_s;
		logic [1:0]  sel0_s;
		logic [1:0]  sel1_s;
	} rtc_osc_s;

	rtc_ref_s q_reg;
	rtc_ref_s q_next;
	rtc_osc_s o_reg;
	rtc_osc_s o_next;

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
	endfunction

	function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		case (mon)
			8'h02: month_len = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
			default: month_len = 8'h31;
		endcase
	endfunction

	// ---------------- oscillator domain ----------------
	always_comb
	begin
		o_next = o_reg;
		o_next.pre = o_reg.pre + 15'h0001;
		if ((o_reg.pre & DIV_4096_MASK) == DIV_4096_MASK)
			o_next.t4k = ~o_reg.t4k;
		if ((o_reg.pre & DIV_64_MASK) == DIV_64_MASK)
			o_next.t64 = ~o_reg.t64;
		if (o_reg.pre == DIV_1HZ_MASK)
			o_next.t1 = ~o_reg.t1;
		o_next.en_s = {o_reg.en_s[0], q_reg.regs[REG_SQW][BIT_SQW_EN]};
		// select bits change only under software control; a glitch lasts one osc cycle
		o_next.sel0_s = {o_reg.sel0_s[0], q_reg.regs[REG_SQW][SEL_LSB]};
		o_next.sel1_s = {o_reg.sel1_s[0], q_reg.regs[REG_SQW][SEL_LSB + 1]};
	end

	always_ff @(posedge osc_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			o_reg <= '{en_s: 2'h3, default: '0};
		else
			o_reg <= o_next;
	end

	logic wave;
	always_comb
	begin
		// the fastest rate is the oscillator itself, so it is passed through ungated
		unique case ({o_reg.sel1_s[1], o_reg.sel0_s[1]})
			2'h0: wave = osc_clk_i;
			2'h1: wave = o_reg.pre[TAP_1024];
			2'h2: wave = o_reg.pre[TAP_32];
			2'h3: wave = o_reg.pre[TAP_1HZ];
		endcase
	end

	assign square_wave_out_o = 1'b0;
	assign square_wave_out_oe_o = o_reg.en_s[1] & ~wave;

	// ---------------- reference domain ----------------
	logic scl_r;
	logic scl_f;
	logic start;
	logic stop;
	logic frozen;
	logic wr_en;
	logic tk4k;
	logic tk64;
	logic tk1;
	logic tkmin;
	logic tmr_tick;
	logic tf_set;
	logic af_set;
	logic osc_dead;
	logic alarm_hit;
	logic en_any;

	assign scl_r  = q_reg.scl_s[1] & ~q_reg.scl_s[2];
	assign scl_f  = ~q_reg.scl_s[1] & q_reg.scl_s[2];
	assign start  = q_reg.scl_s[1] & q_reg.scl_s[2] & q_reg.sda_s[2] & ~q_reg.sda_s[1];
	assign stop   = q_reg.scl_s[1] & q_reg.scl_s[2] & ~q_reg.sda_s[2] & q_reg.sda_s[1];
	assign frozen = (q_reg.st == ST_RDATA) || (q_reg.st == ST_RDATA_ACK);
	assign tk4k   = q_reg.t4k_s[1] ^ q_reg.t4k_s[2];
	assign tk64   = q_reg.t64_s[1] ^ q_reg.t64_s[2];
	assign tk1    = q_reg.t1_s[1] ^ q_reg.t1_s[2];
	assign tkmin  = tk1 && (q_reg.min_div == SEC_LAST);
	assign osc_dead = q_reg.stall >= 17'(OSC_STOP_CYCLES);

	always_comb
	begin
		unique case (q_reg.regs[REG_TMR_CTL][SEL_LSB +: 2])
			2'h0: tmr_tick = tk4k;
			2'h1: tmr_tick = tk64;
			2'h2: tmr_tick = tk1;
			2'h3: tmr_tick = tkmin;
		endcase
	end

	// a disabled field passes; at least one field must be enabled
	assign en_any = ~(q_reg.regs[REG_AL_MIN][BIT_ALARM_MATCH_DIS]
		& q_reg.regs[REG_AL_HOUR][BIT_ALARM_MATCH_DIS]
		& q_reg.regs[REG_AL_DAY][BIT_ALARM_MATCH_DIS]
		& q_reg.regs[REG_AL_WDAY][BIT_ALARM_MATCH_DIS]);
	assign alarm_hit = en_any && (q_reg.regs[REG_SEC][6:0] == 7'h00)
		&& (q_reg.regs[REG_AL_MIN][BIT_ALARM_MATCH_DIS]
			|| q_reg.regs[REG_AL_MIN][6:0] == q_reg.regs[REG_MIN][6:0])
		&& (q_reg.regs[REG_AL_HOUR][BIT_ALARM_MATCH_DIS]
			|| q_reg.regs[REG_AL_HOUR][5:0] == q_reg.regs[REG_HOUR][5:0])
		&& (q_reg.regs[REG_AL_DAY][BIT_ALARM_MATCH_DIS]
			|| q_reg.regs[REG_AL_DAY][5:0] == q_reg.regs[REG_DAY][5:0])
		&& (q_reg.regs[REG_AL_WDAY][BIT_ALARM_MATCH_DIS]
			|| q_reg.regs[REG_AL_WDAY][2:0] == q_reg.regs[REG_WDAY][2:0]);
	assign af_set = q_reg.alarm_chk && alarm_hit;

	always_comb
	begin
		logic [7:0] t;
		t = 8'h00;
		q_next = q_reg;
		wr_en = 1'b0;
		tf_set = 1'b0;
		// pins pass two flops; 100 MHz oversampling covers any rate to 400 kbit/s
		q_next.scl_s   = {q_reg.scl_s[1:0], scl_i};
		q_next.sda_s   = {q_reg.sda_s[1:0], sda_i};
		q_next.low_s   = {q_reg.low_s[0], supply_low_i};
		q_next.alive_s = {q_reg.alive_s[1:0], o_reg.pre[0]};
		q_next.t4k_s   = {q_reg.t4k_s[1:0], o_reg.t4k};
		q_next.t64_s   = {q_reg.t64_s[1:0], o_reg.t64};
		q_next.t1_s    = {q_reg.t1_s[1:0], o_reg.t1};
		if (q_reg.alive_s[1] ^ q_reg.alive_s[2])
			q_next.stall = 17'h00000;
		else if (!osc_dead)
			q_next.stall = q_reg.stall + 17'h00001;

		if (tk1)
			q_next.min_div = tkmin ? 6'h00 : q_reg.min_div + 6'h01;

		// seconds that arrive during a read wait until the read is over
		q_next.alarm_chk = 1'b0;
		q_next.sec_pend = q_reg.sec_pend | tk1;
		if (q_next.sec_pend && !frozen)
		begin
			q_next.sec_pend = 1'b0;
			q_next.alarm_chk = 1'b1;
			t = bcd_inc({1'b0, q_reg.regs[REG_SEC][6:0]});
			q_next.regs[REG_SEC][6:0] = t[6:0];
			if (q_reg.regs[REG_SEC][6:0] == 7'h59)
			begin
				q_next.regs[REG_SEC][6:0] = 7'h00;
				q_next.regs[REG_MIN] = bcd_inc({1'b0, q_reg.regs[REG_MIN][6:0]});
				if (q_reg.regs[REG_MIN][6:0] == 7'h59)
				begin
					q_next.regs[REG_MIN] = 8'h00;
					q_next.regs[REG_HOUR] = bcd_inc({2'h0, q_reg.regs[REG_HOUR][5:0]});
					if (q_reg.regs[REG_HOUR][5:0] == 6'h23)
					begin
						q_next.regs[REG_HOUR] = 8'h00;
						q_next.regs[REG_WDAY] = (q_reg.regs[REG_WDAY][2:0] == 3'h6) ? 8'h00
							: {5'h00, q_reg.regs[REG_WDAY][2:0] + 3'h1};
						q_next.regs[REG_DAY] = bcd_inc({2'h0, q_reg.regs[REG_DAY][5:0]});
						if ({2'h0, q_reg.regs[REG_DAY][5:0]} == month_len(
							{3'h0, q_reg.regs[REG_MON][4:0]}, q_reg.regs[REG_YEAR]))
						begin
							q_next.regs[REG_DAY] = 8'h01;
							t = bcd_inc({3'h0, q_reg.regs[REG_MON][4:0]});
							q_next.regs[REG_MON][6:0] = t[6:0];
							if (q_reg.regs[REG_MON][4:0] == 5'h12)
							begin
								q_next.regs[REG_MON][6:0] = 7'h01;
								q_next.regs[REG_YEAR] = bcd_inc(q_reg.regs[REG_YEAR]);
								if (q_reg.regs[REG_YEAR] == 8'h99)
								begin
									q_next.regs[REG_YEAR] = 8'h00;
									q_next.regs[REG_MON][BIT_CENTURY] =
										~q_reg.regs[REG_MON][BIT_CENTURY];
								end
							end
						end
					end
				end
			end
		end

		// countdown keeps running during reads; the live count is what a read sees
		if (tmr_tick && q_reg.regs[REG_TMR_CTL][BIT_TMR_EN]
			&& q_reg.regs[REG_TMR] != 8'h00)
		begin
			if (q_reg.regs[REG_TMR] == 8'h01)
			begin
				tf_set = 1'b1;
				q_next.regs[REG_TMR] = q_reg.reload;
			end
			else
				q_next.regs[REG_TMR] = q_reg.regs[REG_TMR] - 8'h01;
		end

		if (start)
		begin
			q_next.st = ST_ADDR;
			q_next.cnt = 4'h0;
		end
		else if (stop)
			q_next.st = ST_IDLE;
		else
		begin
			unique case (q_reg.st)
				ST_IDLE: ;
				ST_ADDR, ST_PTR, ST_WDATA:
				begin
					if (scl_r)
					begin
						q_next.shift = {q_reg.shift[6:0], q_reg.sda_s[1]};
						q_next.cnt = q_reg.cnt + 4'h1;
					end
					else if (scl_f && q_reg.cnt == BITS_PER_BYTE)
					begin
						if (q_reg.st == ST_ADDR)
						begin
							q_next.rw = q_reg.shift[0];
							q_next.st = (q_reg.shift == I2C_ADDR_WR || q_reg.shift == I2C_ADDR_RD)
								? ST_ADDR_ACK : ST_IDLE;
						end
						else if (q_reg.st == ST_PTR)
						begin
							q_next.ptr = q_reg.shift[3:0];
							q_next.st = ST_PTR_ACK;
						end
						else
						begin
							wr_en = 1'b1;
							q_next.ptr = q_reg.ptr + 4'h1;
							q_next.st = ST_WDATA_ACK;
						end
					end
				end
				ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK:
				begin
					if (scl_f)
					begin
						q_next.cnt = 4'h0;
						if (q_reg.st == ST_ADDR_ACK && q_reg.rw)
						begin
							q_next.shift = q_reg.regs[q_reg.ptr];
							q_next.st = ST_RDATA;
						end
						else
							q_next.st = (q_reg.st == ST_ADDR_ACK) ? ST_PTR : ST_WDATA;
					end
				end
				ST_RDATA:
				begin
					if (scl_r)
						q_next.cnt = q_reg.cnt + 4'h1;
					else if (scl_f && q_reg.cnt == BITS_PER_BYTE)
					begin
						q_next.ptr = q_reg.ptr + 4'h1;
						q_next.st = ST_RDATA_ACK;
					end
					else if (scl_f)
						q_next.shift = {q_reg.shift[6:0], 1'b0};
				end
				ST_RDATA_ACK:
				begin
					if (scl_r)
						q_next.nack = q_reg.sda_s[1];
					else if (scl_f && q_reg.nack)
						q_next.st = ST_IDLE;
					else if (scl_f)
					begin
						q_next.shift = q_reg.regs[q_reg.ptr];
						q_next.cnt = 4'h0;
						q_next.st = ST_RDATA;
					end
				end
			endcase
		end

		// reserved bits are stored as written, software keeps them zero
		if (wr_en)
		begin
			q_next.regs[q_reg.ptr] = q_reg.shift;
			if (q_reg.ptr == REG_CTRL_B)
			begin
				// a one written to a flag leaves it; only a zero clears
				q_next.regs[REG_CTRL_B][BIT_ALARM_FLAG] =
					q_reg.shift[BIT_ALARM_FLAG] & q_reg.regs[REG_CTRL_B][BIT_ALARM_FLAG];
				q_next.regs[REG_CTRL_B][BIT_CD_FLAG] =
					q_reg.shift[BIT_CD_FLAG] & q_reg.regs[REG_CTRL_B][BIT_CD_FLAG];
			end
			if (q_reg.ptr == REG_TMR)
				q_next.reload = q_reg.shift;
		end
		// hardware sets win over a clear in the same cycle
		if (af_set)
			q_next.regs[REG_CTRL_B][BIT_ALARM_FLAG] = 1'b1;
		if (tf_set)
			q_next.regs[REG_CTRL_B][BIT_CD_FLAG] = 1'b1;
		if (q_reg.low_s[1])
			q_next.regs[REG_SEC][BIT_SUPPLY_LOW] = 1'b1;

		if (tf_set && q_reg.regs[REG_CTRL_B][BIT_IRQ_PULSE_SELECT])
			q_next.pulse = 10'(IRQ_PULSE_CYCLES);
		else if (q_reg.pulse != 10'h000)
			q_next.pulse = q_reg.pulse - 10'h001;
		q_next.int_oe = (q_reg.regs[REG_CTRL_B][BIT_ALARM_FLAG]
			& q_reg.regs[REG_CTRL_B][BIT_ALARM_IRQ_EN])
			| (q_reg.regs[REG_CTRL_B][BIT_CD_IRQ_EN]
			& (q_reg.regs[REG_CTRL_B][BIT_IRQ_PULSE_SELECT] ? (q_reg.pulse != 10'h000)
			: q_reg.regs[REG_CTRL_B][BIT_CD_FLAG]));

		if (osc_dead)
		begin
			q_next.regs = REG_RST;
			q_next.reload = 8'h00;
			q_next.st = ST_IDLE;
			q_next.sec_pend = 1'b0;
			q_next.pulse = 10'h000;
			q_next.int_oe = 1'b0;
		end
		q_next.sda_oe = (q_next.st == ST_ADDR_ACK) || (q_next.st == ST_PTR_ACK)
			|| (q_next.st == ST_WDATA_ACK) || (q_next.st == ST_RDATA && !q_next.shift[7]);
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			q_reg <= '{regs: REG_RST, scl_s: 3'h7, sda_s: 3'h7, st: ST_IDLE, default: '0};
		else
			q_reg <= q_next;
	end

	assign sda_o = 1'b0;
	assign sda_oe_o = q_reg.sda_oe;
	assign int_o = 1'b0;
	assign int_oe_o = q_reg.int_oe;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	a_wr_ptr_step: assert property ((q_reg.st == ST_WDATA && scl_f && q_reg.cnt == BITS_PER_BYTE && !start && !stop && !osc_dead) |=> q_reg.ptr == $past(q_reg.ptr) + 4'h1) else $error("ptr not advanced");
	a_read_freeze: assert property ((frozen && !osc_dead) |=> $stable(q_reg.regs[REG_SEC][6:0]) || !$past(frozen)) else $error("seconds moved during read");
	a_af_sticky: assert property ((q_reg.regs[REG_CTRL_B][BIT_ALARM_FLAG] && !wr_en && !osc_dead) |=> q_reg.regs[REG_CTRL_B][BIT_ALARM_FLAG]) else $error("alarm flag lost");
	a_tf_sticky: assert property ((q_reg.regs[REG_CTRL_B][BIT_CD_FLAG] && !wr_en && !osc_dead) |=> q_reg.regs[REG_CTRL_B][BIT_CD_FLAG]) else $error("done flag lost");
	a_vl_sticky: assert property ((q_reg.regs[REG_SEC][BIT_SUPPLY_LOW] && !wr_en && !osc_dead) |=> q_reg.regs[REG_SEC][BIT_SUPPLY_LOW]) else $error("supply flag lost");
	a_low_sets: assert property ((q_reg.low_s[1] && !osc_dead) |=> q_reg.regs[REG_SEC][BIT_SUPPLY_LOW]) else $error("supply flag not set");
	a_bad_addr: assert property ((q_reg.st == ST_ADDR && scl_f && q_reg.cnt == BITS_PER_BYTE && !start && !stop && !osc_dead && q_reg.shift != I2C_ADDR_WR && q_reg.shift != I2C_ADDR_RD) |=> q_reg.st == ST_IDLE ##1 !sda_oe_o) else $error("foreign address acknowledged");
	a_tmr_reload: assert property ((tf_set && !wr_en && !osc_dead) |=> q_reg.regs[REG_TMR] == q_reg.reload && q_reg.regs[REG_CTRL_B][BIT_CD_FLAG]) else $error("timer end wrong");
	a_int_enable: assert property ((!q_reg.regs[REG_CTRL_B][BIT_ALARM_IRQ_EN] && !q_reg.regs[REG_CTRL_B][BIT_CD_IRQ_EN]) |=> !int_oe_o) else $error("interrupt without enable");
	a_stop_reset: assert property (osc_dead |=> q_reg.regs == REG_RST && q_reg.st == ST_IDLE) else $error("no reset on stopped oscillator");

	c_alarm_hit: cover property (af_set);
	c_timer_end: cover property (tf_set);
	c_read_byte: cover property (q_reg.st == ST_RDATA ##[1:1000] q_reg.st == ST_RDATA_ACK);
	c_write_byte: cover property (wr_en);
endmodule

// File: core/rtc_pkg.sv
package rtc_pkg;
// Behaviour
// - sixteen byte registers selected by an internal register pointer
// - pointer advances by one after each data byte, read or write
// - 00h-01h control and status; 02h-08h seconds up to years counters
// - 09h-0Ch alarm, 0Dh square wave, 0Eh timer control, 0Fh timer value
// - time, date and alarm values are kept in BCD
// - counters stay frozen while timekeeping registers are being read
// - an alarm field is compared only when its match-disable bit is zero
// - alarm condition sets a sticky alarm flag cleared by software
// - eight-bit countdown timer at 0Fh governed by control at 0Eh
// - timer control picks 4096 Hz, 64 Hz, 1 Hz or 1/60 Hz and enables
// - timer counts down from loaded value and sets done flag at each end
// - countdown-done flag is cleared only by a software write
// - pulse-select bit picks a pulse per countdown or a level following the flag
// - reading the timer value returns the live remaining count
// - square wave 32.768 kHz, 1024 Hz, 32 Hz or 1 Hz, default 32.768 kHz
// - square wave is open-drain, enabled after reset, floats when disabled
// - a stopped oscillator holds the device in reset, registers reinitialised
// - supply-low sets a sticky flag in the seconds register until cleared
// - interrupt output is open-drain and active low
// - device answers only address bytes A2h for write and A3h for read
// - device works at any bus rate up to 400 kbit/s

	localparam logic [3:0] REG_CTRL_A  = 4'h0;
	localparam logic [3:0] REG_CTRL_B  = 4'h1;
	localparam logic [3:0] REG_SEC     = 4'h2;
	localparam logic [3:0] REG_MIN     = 4'h3;
	localparam logic [3:0] REG_HOUR    = 4'h4;
	localparam logic [3:0] REG_DAY     = 4'h5;
	localparam logic [3:0] REG_WDAY    = 4'h6;
	localparam logic [3:0] REG_MON     = 4'h7;
	localparam logic [3:0] REG_YEAR    = 4'h8;
	localparam logic [3:0] REG_AL_MIN  = 4'h9;
	localparam logic [3:0] REG_AL_HOUR = 4'hA;
	localparam logic [3:0] REG_AL_DAY  = 4'hB;
	localparam logic [3:0] REG_AL_WDAY = 4'hC;
	localparam logic [3:0] REG_SQW     = 4'hD;
	localparam logic [3:0] REG_TMR_CTL = 4'hE;
	localparam logic [3:0] REG_TMR     = 4'hF;

	localparam int BIT_IRQ_PULSE_SELECT = 4;
	localparam int BIT_ALARM_FLAG       = 3;
	localparam int BIT_CD_FLAG          = 2;
	localparam int BIT_ALARM_IRQ_EN     = 1;
	localparam int BIT_CD_IRQ_EN        = 0;
	localparam int BIT_SUPPLY_LOW       = 7;
	localparam int BIT_ALARM_MATCH_DIS  = 7;
	localparam int BIT_CENTURY          = 7;
	localparam int BIT_SQW_EN           = 7;
	localparam int BIT_TMR_EN           = 7;
	localparam int SEL_LSB              = 0;

	// index 15 down to 0
	localparam logic [15:0][7:0] REG_RST = {8'h00, 8'h03, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80,
		8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};

	localparam logic [7:0]  I2C_ADDR_WR   = 8'hA2;
	localparam logic [7:0]  I2C_ADDR_RD   = 8'hA3;
	localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
	localparam logic [5:0]  SEC_LAST      = 6'h3B;
	localparam logic [14:0] DIV_4096_MASK = 15'h0007;
	localparam logic [14:0] DIV_64_MASK   = 15'h01FF;
	localparam logic [14:0] DIV_1HZ_MASK  = 15'h7FFF;
	localparam int TAP_1024 = 4;
	localparam int TAP_32   = 9;
	localparam int TAP_1HZ  = 14;

	localparam int CLK_PERIOD_NS       = 10;
	localparam int IRQ_PULSE_NS        = 10000;
	localparam int IRQ_PULSE_CYCLES    = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OSC_STOP_NS         = 100000;
	localparam int OSC_STOP_CYCLES_DEF = OSC_STOP_NS / CLK_PERIOD_NS;
endpackage
